// ---- core/adc_irq_flags.sv ----
// interrupt flags, live status and interrupt output routing
`timescale 1ns/1ps
`default_nettype none

module adc_irq_flags
#(
  parameter int unsigned PULSE_WIDTH_CYC  = irq_pkg::PULSE_WIDTH_CYC,
  parameter int unsigned PULSE_PERIOD_CYC = irq_pkg::PULSE_PERIOD_CYC
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  input  wire logic       noise_below_left,
  input  wire logic       noise_below_right,
  input  wire logic       engine_irq_std,
  input  wire logic       engine_irq_aux,
  input  wire logic       overflow_left,
  input  wire logic       overflow_right,
  input  wire logic       overflow_barrel,
  input  wire logic       data_available,
  output wire logic       first_irq_output,
  output wire logic       second_irq_output
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] sticky_next(input logic [7:0] cur, input logic clr, input logic [7:0] set);
    // a set in the clearing cycle survives
    sticky_next = (cur & {8{~clr}}) | set;
  endfunction

  function automatic logic [7:0] ctrl_next(input logic [7:0] cur, input logic wr, input logic [7:0] data);
    ctrl_next = wr ? (data & irq_pkg::CTRL_WRITE_MASK) : cur;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] latched_q;
  logic [7:0] latched_d;
  logic [7:0] overflow_q;
  logic [7:0] overflow_d;
  logic [7:0] first_ctrl_q;
  logic [7:0] first_ctrl_d;
  logic [7:0] second_ctrl_q;
  logic [7:0] second_ctrl_d;
  logic [3:0] level_prev_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire sel_overflow = (reg_addr == irq_pkg::OVERFLOW_FLAGS_ADDR);
  wire sel_latched  = (reg_addr == irq_pkg::LATCHED_FLAGS_ADDR);
  wire sel_live     = (reg_addr == irq_pkg::LIVE_STATUS_ADDR);
  wire sel_first    = (reg_addr == irq_pkg::FIRST_IRQ_CTRL_ADDR);
  wire sel_second   = (reg_addr == irq_pkg::SECOND_IRQ_CTRL_ADDR);

  wire rd_overflow  = reg_rd && sel_overflow;
  wire rd_latched   = reg_rd && sel_latched;
  // reserved registers at 0x2c, 0x2e, 0x32 decode to nothing and ignore writes
  wire wr_first     = reg_wr && sel_first;
  wire wr_second    = reg_wr && sel_second;

  // ****************************************************************
  // source edges
  // ****************************************************************
  // history resets low: a source already high at release counts as a new event
  wire [3:0] level_now  = {noise_below_left, noise_below_right, engine_irq_std, engine_irq_aux};
  wire [3:0] level_rise = level_now & ~level_prev_q;

  wire noise_event    = level_rise[3] | level_rise[2];
  wire overflow_event = overflow_left | overflow_right | overflow_barrel;
  wire engine_event   = level_rise[1] | level_rise[0] | overflow_event;

  wire [7:0] latched_set;
  wire [7:0] overflow_set;

  assign latched_set = (8'(level_rise[3]) << irq_pkg::NOISE_LEFT_BIT)
                     | (8'(level_rise[2]) << irq_pkg::NOISE_RIGHT_BIT)
                     | (8'(level_rise[1]) << irq_pkg::ENGINE_STD_BIT)
                     | (8'(level_rise[0]) << irq_pkg::ENGINE_AUX_BIT);

  // overflow inputs are events: every high cycle sets its flag again
  assign overflow_set = (8'(overflow_left)   << irq_pkg::OVF_LEFT_BIT)
                      | (8'(overflow_right)  << irq_pkg::OVF_RIGHT_BIT)
                      | (8'(overflow_barrel) << irq_pkg::OVF_BARREL_BIT);

  assign latched_d  = sticky_next(latched_q, rd_latched, latched_set);
  assign overflow_d = sticky_next(overflow_q, rd_overflow, overflow_set);

  // ****************************************************************
  // live status
  // ****************************************************************
  wire [7:0] live_status = (8'(noise_below_left)  << irq_pkg::NOISE_LEFT_BIT)
                         | (8'(noise_below_right) << irq_pkg::NOISE_RIGHT_BIT)
                         | (8'(engine_irq_std)    << irq_pkg::ENGINE_STD_BIT)
                         | (8'(engine_irq_aux)    << irq_pkg::ENGINE_AUX_BIT);

  // ****************************************************************
  // control registers
  // ****************************************************************
  // reserved control bits are masked off and always read back as zero
  assign first_ctrl_d  = ctrl_next(first_ctrl_q, wr_first, reg_wdata);
  assign second_ctrl_d = ctrl_next(second_ctrl_q, wr_second, reg_wdata);

  // ****************************************************************
  // read data
  // ****************************************************************
  // read data is registered and holds until the next read strobe
  assign rdata_d = !reg_rd     ? rdata_q
                 : sel_overflow ? overflow_q
                 : sel_latched  ? latched_q
                 : sel_live     ? live_status
                 : sel_first    ? first_ctrl_q
                 : sel_second   ? second_ctrl_q
                 : irq_pkg::READ_ZERO;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      latched_q     <= irq_pkg::FLAGS_RESET;
      overflow_q    <= irq_pkg::FLAGS_RESET;
      first_ctrl_q  <= irq_pkg::CTRL_RESET;
      second_ctrl_q <= irq_pkg::CTRL_RESET;
      level_prev_q  <= '0;
      rdata_q       <= irq_pkg::READ_ZERO;
    end
    else
    begin
      latched_q     <= latched_d;
      overflow_q    <= overflow_d;
      first_ctrl_q  <= first_ctrl_d;
      second_ctrl_q <= second_ctrl_d;
      level_prev_q  <= level_now;
      rdata_q       <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // output routing
  // ****************************************************************
  // reading either flag register ends a repeating sequence on both outputs
  wire flags_read = rd_overflow | rd_latched;

  // events that arrive while a generator is busy merge into its running pulse
  wire first_trigger  = (first_ctrl_q[irq_pkg::EN_NOISE_BIT]   & noise_event)
                      | (first_ctrl_q[irq_pkg::EN_ENGINE_BIT]  & engine_event)
                      | (first_ctrl_q[irq_pkg::EN_DATA_BIT]    & data_available);
  wire second_trigger = (second_ctrl_q[irq_pkg::EN_NOISE_BIT]  & noise_event)
                      | (second_ctrl_q[irq_pkg::EN_ENGINE_BIT] & engine_event)
                      | (second_ctrl_q[irq_pkg::EN_DATA_BIT]   & data_available);

  pulse_if first_pif ();
  pulse_if second_pif ();

  assign first_pif.trigger      = first_trigger;
  assign first_pif.repeat_mode  = first_ctrl_q[irq_pkg::REPEAT_MODE_BIT];
  assign first_pif.stop         = flags_read;
  assign second_pif.trigger     = second_trigger;
  assign second_pif.repeat_mode = second_ctrl_q[irq_pkg::REPEAT_MODE_BIT];
  assign second_pif.stop        = flags_read;

  irq_pulse_gen
  #(
    .WIDTH_CYC  (PULSE_WIDTH_CYC),
    .PERIOD_CYC (PULSE_PERIOD_CYC)
  )
  first_gen
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pif     (first_pif.gen)
  );

  irq_pulse_gen
  #(
    .WIDTH_CYC  (PULSE_WIDTH_CYC),
    .PERIOD_CYC (PULSE_PERIOD_CYC)
  )
  second_gen
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pif     (second_pif.gen)
  );

  assign first_irq_output  = first_pif.irq_out;
  assign second_irq_output = second_pif.irq_out;

endmodule

`default_nettype wire

// ---- shared/irq_pkg.sv ----
// constants shared by the interrupt flag and pin logic
package irq_pkg;

  // ****************************************************************
  // register offsets (page 0)
  // ****************************************************************
  localparam logic [7:0] OVERFLOW_FLAGS_ADDR     = 8'h2a;
  localparam logic [7:0] RESERVED_A_ADDR         = 8'h2c;
  localparam logic [7:0] LATCHED_FLAGS_ADDR      = 8'h2d;
  localparam logic [7:0] RESERVED_B_ADDR         = 8'h2e;
  localparam logic [7:0] LIVE_STATUS_ADDR        = 8'h2f;
  localparam logic [7:0] FIRST_IRQ_CTRL_ADDR     = 8'h30;
  localparam logic [7:0] SECOND_IRQ_CTRL_ADDR    = 8'h31;
  localparam logic [7:0] RESERVED_C_ADDR         = 8'h32;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned NOISE_LEFT_BIT   = 6;
  localparam int unsigned NOISE_RIGHT_BIT  = 5;
  localparam int unsigned ENGINE_STD_BIT   = 4;
  localparam int unsigned ENGINE_AUX_BIT   = 3;
  localparam int unsigned OVF_LEFT_BIT     = 3;
  localparam int unsigned OVF_RIGHT_BIT    = 2;
  localparam int unsigned OVF_BARREL_BIT   = 1;
  localparam int unsigned EN_NOISE_BIT     = 4;
  localparam int unsigned EN_ENGINE_BIT    = 2;
  localparam int unsigned EN_DATA_BIT      = 1;
  localparam int unsigned REPEAT_MODE_BIT  = 0;

  // writable bits of the control registers, reset values
  localparam logic [7:0] CTRL_WRITE_MASK   = 8'h17;
  localparam logic [7:0] CTRL_RESET        = 8'h00;
  localparam logic [7:0] FLAGS_RESET       = 8'h00;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // ****************************************************************
  // pulse timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned PULSE_WIDTH_US   = 2000;
  localparam int unsigned PULSE_PERIOD_US  = 4000;
  localparam int unsigned PULSE_WIDTH_CYC  = (PULSE_WIDTH_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_PERIOD_CYC = (PULSE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 17;

  typedef enum logic [1:0]
  {
    PULSE_IDLE = 2'b00,
    PULSE_HIGH = 2'b01,
    PULSE_LOW  = 2'b10
  } pulse_state_t;

endpackage

// ---- shared/pulse_if.sv ----
// carrier between the flag logic and one interrupt pulse generator
`timescale 1ns/1ps
`default_nettype none

interface pulse_if;
  logic trigger;
  logic repeat_mode;
  logic stop;
  logic irq_out;

  modport ctrl
  (
    output trigger,
    output repeat_mode,
    output stop,
    input  irq_out
  );

  modport gen
  (
    input  trigger,
    input  repeat_mode,
    input  stop,
    output irq_out
  );
endinterface

`default_nettype wire

// ---- core/irq_pulse_gen.sv ----
// single or repeated interrupt pulse generator for one output
`timescale 1ns/1ps
`default_nettype none

module irq_pulse_gen
#(
  parameter int unsigned WIDTH_CYC  = irq_pkg::PULSE_WIDTH_CYC,
  parameter int unsigned PERIOD_CYC = irq_pkg::PULSE_PERIOD_CYC
)
(
  input  wire logic clk_sys,
  input  wire logic rst,
  pulse_if.gen      pif
);

  localparam logic [irq_pkg::CNT_W-1:0] HIGH_LAST = irq_pkg::CNT_W'(WIDTH_CYC - 1);
  localparam logic [irq_pkg::CNT_W-1:0] LOW_LAST  = irq_pkg::CNT_W'(PERIOD_CYC - WIDTH_CYC - 1);

  irq_pkg::pulse_state_t       state_q;
  irq_pkg::pulse_state_t       state_d;
  logic [irq_pkg::CNT_W-1:0]   cnt_q;
  logic [irq_pkg::CNT_W-1:0]   cnt_d;
  logic                        out_q;

  wire high_done = (cnt_q == HIGH_LAST);
  wire low_done  = (cnt_q == LOW_LAST);
  wire halt      = pif.repeat_mode && pif.stop;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    case (state_q)
      irq_pkg::PULSE_IDLE:
      begin
        cnt_d = '0;
        if (pif.trigger)
          state_d = irq_pkg::PULSE_HIGH;
      end
      irq_pkg::PULSE_HIGH:
      begin
        if (halt)
        begin
          state_d = irq_pkg::PULSE_IDLE;
          cnt_d   = '0;
        end
        else if (high_done)
        begin
          state_d = pif.repeat_mode ? irq_pkg::PULSE_LOW : irq_pkg::PULSE_IDLE;
          cnt_d   = '0;
        end
      end
      irq_pkg::PULSE_LOW:
      begin
        if (halt || !pif.repeat_mode)
        begin
          state_d = irq_pkg::PULSE_IDLE;
          cnt_d   = '0;
        end
        else if (low_done)
        begin
          state_d = irq_pkg::PULSE_HIGH;
          cnt_d   = '0;
        end
      end
      default:
      begin
        state_d = irq_pkg::PULSE_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= irq_pkg::PULSE_IDLE;
      cnt_q   <= '0;
      out_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      out_q   <= (state_d == irq_pkg::PULSE_HIGH);
    end
  end

  assign pif.irq_out = out_q;

endmodule

`default_nettype wire

// ---- tb/irq_host.sv ----
// host processor model driving the register strobes
`timescale 1ns/1ps
`default_nettype none
module irq_host
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_rd,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // scenarios never write reserved registers or reserved control bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    // a released bus shows the inverse of its last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- tb/adc_irq_flags_props.sv ----
// assertion checker for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module adc_irq_flags_props
#(
  parameter int unsigned PULSE_WIDTH_CYC  = 4,
  parameter int unsigned PULSE_PERIOD_CYC = 10
)
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       noise_below_left,
  input wire logic       noise_below_right,
  input wire logic       engine_irq_std,
  input wire logic       engine_irq_aux,
  input wire logic       overflow_left,
  input wire logic       overflow_right,
  input wire logic       overflow_barrel,
  input wire logic       data_available,
  input wire logic       first_irq_output,
  input wire logic       second_irq_output
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [3:0] in_q;
  logic [3:0] in_now;
  logic       stop_rd;
  logic       rd_l;
  logic       quiet;
  assign in_now = {noise_below_left, noise_below_right, engine_irq_std, engine_irq_aux};
  assign stop_rd = reg_rd && (reg_addr == 8'h2a || reg_addr == 8'h2d);
  assign rd_l = reg_rd && reg_addr == 8'h2d;
  assign quiet = in_q == in_now;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      in_q <= 4'h0;
    end
    else
    begin
      in_q <= in_now;
      if (reg_wr && reg_addr == 8'h30)
        c1_q <= reg_wdata & 8'h17;
      if (reg_wr && reg_addr == 8'h31)
        c2_q <= reg_wdata & 8'h17;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // repetition counts assume a width of 4 and a period of 10 cycles
  property p_rsvd;
    reg_rd && (reg_addr == 8'h2c || reg_addr == 8'h2e || reg_addr == 8'h32) |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_live;
    reg_rd && reg_addr == 8'h2f |=> reg_rdata == {1'b0, $past(in_now), 3'h0};
  endproperty
  a_live: assert property (p_live) else $error("live status wrong");
  property p_ctrl;
    reg_rd && (reg_addr == 8'h30 || reg_addr == 8'h31) |=> reg_rdata == $past(reg_addr[0] ? c2_q : c1_q);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_width1;
    disable iff (rst || (c1_q[0] && stop_rd))
    $rose(first_irq_output) |-> first_irq_output [*4] ##1 !first_irq_output;
  endproperty
  a_width1: assert property (p_width1) else $error("first pulse width wrong");
  property p_width2;
    disable iff (rst || (c2_q[0] && stop_rd))
    $rose(second_irq_output) |-> second_irq_output [*4] ##1 !second_irq_output;
  endproperty
  a_width2: assert property (p_width2) else $error("second pulse width wrong");
  property p_repeat1;
    disable iff (rst || stop_rd || !c1_q[0])
    $fell(first_irq_output) && c1_q[0] && !$past(stop_rd) && !$past(stop_rd, 2)
      |-> (!first_irq_output) [*6] ##1 first_irq_output;
  endproperty
  a_repeat1: assert property (p_repeat1) else $error("first repeat period wrong");
  property p_stop2;
    stop_rd && c2_q[0] && second_irq_output |-> ##1 !second_irq_output;
  endproperty
  a_stop2: assert property (p_stop2) else $error("second pulses not stopped");
  property p_clear;
    rd_l && quiet ##1 quiet ##1 rd_l && quiet |=> reg_rdata[6:3] == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky flags not cleared");
  c_rep1: cover property ($rose(first_irq_output) && c1_q[0]);
  c_rise2: cover property ($rose(second_irq_output));
  c_stop2: cover property (stop_rd && c2_q[0] && second_irq_output);
endmodule
bind adc_irq_flags adc_irq_flags_props
#(
  .PULSE_WIDTH_CYC(PULSE_WIDTH_CYC),
  .PULSE_PERIOD_CYC(PULSE_PERIOD_CYC)
)
props
(
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .noise_below_left(noise_below_left),
  .noise_below_right(noise_below_right), .engine_irq_std(engine_irq_std), .engine_irq_aux(engine_irq_aux),
  .overflow_left(overflow_left), .overflow_right(overflow_right), .overflow_barrel(overflow_barrel),
  .data_available(data_available), .first_irq_output(first_irq_output), .second_irq_output(second_irq_output)
);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, hi, lo;
  logic reg_rd, reg_wr, first_irq_output, second_irq_output;
  logic nl = 1'b0, nr = 1'b0, es = 1'b0, ea = 1'b0, ov = 1'b0, dav = 1'b0;
  logic [1:0] irq;
  int n_errors = 0;
  int compares = 0;
  assign irq = {second_irq_output, first_irq_output};
  always #20 clk_sys = ~clk_sys;
  adc_irq_flags #(.PULSE_WIDTH_CYC(4), .PULSE_PERIOD_CYC(10)) dut
  (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .noise_below_left(nl), .noise_below_right(nr),
    .engine_irq_std(es), .engine_irq_aux(ea), .overflow_left(ov), .overflow_right(ov),
    .overflow_barrel(ov), .data_available(dav), .first_irq_output(first_irq_output),
    .second_irq_output(second_irq_output)
  );
  irq_host host
  (
    .clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  // counts high cycles, then low cycles up to 20, of one output
  task automatic measure(input int w);
    int k;
    @(negedge clk_sys);
    hi = 8'h00;
    lo = 8'h00;
    for (k = 0; k < 40 && irq[w] !== 1'b1; k++) @(negedge clk_sys);
    while (irq[w] === 1'b1 && hi < 8'd40)
    begin
      hi++;
      @(negedge clk_sys);
    end
    while (irq[w] !== 1'b1 && lo < 8'd20)
    begin
      lo++;
      @(negedge clk_sys);
    end
    step;
  endtask
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h2a, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32};
    foreach (a[i])
    begin
      host.rd(a[i], d);
      chk(d, 8'h00);
    end
    host.wr(8'h30, 8'h17);
    host.wr(8'h31, 8'h00);
    host.rd(8'h30, d);
    chk(d, 8'h17);
    host.rd(8'h31, d);
    chk(d, 8'h00);
    host.rd(8'h2c, d);
    chk(d, 8'h00);
    host.wr(8'h31, 8'h16);
    host.wr(8'h30, 8'h00);
    host.rd(8'h31, d);
    chk(d, 8'h16);
  endtask
  task automatic t_flags;
    nl = 1'b1;
    ea = 1'b1;
    step;
    chk({6'h0, irq}, 8'h02);
    host.rd(8'h2f, d);
    chk(d, 8'h48);
    host.rd(8'h2d, d);
    chk(d, 8'h48);
    nl = 1'b0;
    ea = 1'b0;
    host.rd(8'h2d, d);
    chk(d, 8'h00);
    host.rd(8'h2f, d);
    chk(d, 8'h00);
    nr = 1'b1;
    es = 1'b1;
    host.rd(8'h2f, d);
    chk(d, 8'h30);
    host.rd(8'h2d, d);
    chk(d, 8'h30);
    nr = 1'b0;
    es = 1'b0;
  endtask
  task automatic t_single;
    host.wr(8'h30, 8'h10);
    nr = 1'b1;
    measure(0);
    chk(hi, 8'd4);
    chk(lo, 8'd20);
    nr = 1'b0;
  endtask
  task automatic t_repeat2;
    host.wr(8'h31, 8'h05);
    step;
    ov = 1'b1;
    step;
    ov = 1'b0;
    chk({6'h0, irq}, 8'h02);
    measure(1);
    chk(hi, 8'd4);
    chk(lo, 8'd6);
    host.rd(8'h2a, d);
    chk(d, 8'h0e);
    step;
    measure(1);
    chk(hi, 8'd0);
  endtask
  task automatic t_repeat1;
    host.wr(8'h30, 8'h03);
    dav = 1'b1;
    step;
    dav = 1'b0;
    chk({6'h0, irq}, 8'h01);
    measure(0);
    chk(hi, 8'd4);
    chk(lo, 8'd6);
    host.rd(8'h2d, d);
    chk(d, 8'h20);
    host.rd(8'h2d, d);
    chk(d, 8'h00);
    step;
    measure(0);
    chk(hi, 8'd0);
  endtask
  task automatic t_reset;
    host.wr(8'h30, 8'h11);
    nl = 1'b1;
    ov = 1'b1;
    step;
    ov = 1'b0;
    rst = 1'b1;
    step;
    chk({6'h0, irq}, 8'h00);
    rst = 1'b0;
    host.rd(8'h30, d);
    chk(d, 8'h00);
    host.rd(8'h2a, d);
    chk(d, 8'h00);
    host.rd(8'h2d, d);
    chk(d, 8'h40);
    nl = 1'b0;
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_regs;
    t_flags;
    t_single;
    t_repeat2;
    t_repeat1;
    t_reset;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
